// ### bench/iams_checker.sv
// Port checker for the acknowledge and stop sequencer.
`timescale 1ns/1ps
module iams_checker (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic [iams_pkg::WB_DW-1:0] wb_dat_o,
    input wire logic wb_ack_o,
    input wire logic scl_i,
    input wire logic scl_o,
    input wire logic scl_oe_o,
    input wire logic sda_o,
    input wire logic sda_oe_o
);
    import iams_pkg::*;
    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (rst_i);
    // ****************
    // Named steps.
    // ****************
    sequence req_taken;
        wb_cyc_i && wb_stb_i && !wb_ack_o;
    endsequence
    sequence ack_once;
        wb_ack_o ##1 !wb_ack_o;
    endsequence
    sequence line_was_high;
        $past(scl_i, 1) && $past(scl_i, 2) && $past(scl_i, 3);
    endsequence
    // ****************
    // Properties.
    // ****************
    bus_answer_a: assert property (req_taken |=> ack_once)
        else $error("bus request not answered by one ack pulse");
    ack_cause_a: assert property (wb_ack_o |-> $past(wb_cyc_i) && $past(wb_stb_i))
        else $error("ack without a request");
    rdata_idle_a: assert property (!wb_ack_o |-> wb_dat_o == '0)
        else $error("read data not zero outside ack");
    sda_change_a: assert property ($rose(sda_oe_o) |-> scl_oe_o)
        else $error("data line pulled while clock free");
    scl_hold_a: assert property ($fell(scl_oe_o) |-> $past(scl_oe_o, 2) && $past(scl_oe_o, 3))
        else $error("clock released too early");
    scl_arb_a: assert property ($rose(scl_oe_o) |-> line_was_high)
        else $error("clock pulled low before line seen high");
    sda_release_a: assert property ($fell(sda_oe_o) && !scl_oe_o |-> !$past(scl_oe_o, 3))
        else $error("data released too soon after clock");
    od_value_a: assert property (!scl_o && !sda_o)
        else $error("open drain value not low");
endmodule : iams_checker

bind iams_top iams_checker u_chk (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i),
    .wb_stb_i(wb_stb_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .scl_i(scl_i),
    .scl_o(scl_o), .scl_oe_o(scl_oe_o), .sda_o(sda_o), .sda_oe_o(sda_oe_o));

// ### bench/iams_slave.sv
// Far-side model: bus pull-ups and a target that can stretch the clock.
`timescale 1ns/1ps
module iams_slave (
    input wire logic clk_i,
    input wire logic scl_oe_i,
    input wire logic sda_oe_i,
    input wire logic [7:0] stretch_i,
    output logic scl_line_o,
    output logic sda_line_o
);
    // ****************
    // Clock stretching.
    // ****************
    logic [7:0] hold_cnt = 8'h00;
    // The count is armed while the master holds SCL, so the line never glitches high.
    always_ff @(posedge clk_i) begin
        if (scl_oe_i) begin
            hold_cnt <= stretch_i;
        end else if (hold_cnt != 8'h00) begin
            hold_cnt <= hold_cnt - 8'h01;
        end
    end
    assign scl_line_o = !(scl_oe_i || hold_cnt != 8'h00);
    assign sda_line_o = !sda_oe_i;
endmodule : iams_slave

// ### bench/iams_top_test.sv
// Self-checking bench for the acknowledge and stop sequencer.
`timescale 1ns/1ps
`define CHK(nm, exp, got) begin num_checks++; if ((got) !== (exp)) begin n_errors++; \
    $display("[ERR] %s expected %h seen %h", nm, exp, got); end end
module iams_top_test;
    import iams_pkg::*;
    localparam logic [7:0] BAUD = 8'h05;
    localparam int T = 6;
    localparam logic [16:0] ROWS [21] = '{
        {1'b0, OFS_CTRL, 8'h00}, {1'b0, OFS_STAT, 8'h00}, {1'b0, OFS_BAUD, 8'h09},
        {1'b0, OFS_BUF, 8'h00}, {1'b0, OFS_IRQ, 8'h00}, {1'b0, OFS_MASK, 8'h00},
        {1'b0, OFS_BUSY, 8'h00}, {1'b0, 8'h1c, 8'h00}, {1'b1, 8'h1c, 8'hff},
        {1'b0, 8'h1c, 8'h00}, {1'b1, OFS_BAUD, BAUD}, {1'b0, OFS_BAUD, BAUD},
        {1'b1, OFS_MASK, 8'h03}, {1'b0, OFS_MASK, 8'h03}, {1'b1, OFS_BUF, 8'h5a},
        {1'b0, OFS_BUF, 8'h5a}, {1'b0, OFS_STAT, 8'h04}, {1'b0, OFS_BUSY, 8'h01},
        {1'b1, OFS_CTRL, 8'h01}, {1'b0, OFS_CTRL, 8'h01}, {1'b1, OFS_CTRL, 8'h00}};
    logic clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic cyc = 1'b0, stb = 1'b0, we = 1'b0;
    logic [7:0] adr = 8'h00, rd, stretch = 8'h00;
    logic [3:0] sel = 4'h0;
    logic [31:0] wdat = '0, rdat;
    logic ack, irq, scl, sda, scl_od, sda_od, scl_oe, sda_oe;
    logic scl_q = 1'b0, sda_q = 1'b0, sda_at_rel = 1'b0;
    int n_errors = 0, num_checks = 0, now = 0, t_edge = 0, t_sda = 0;
    int hold_len = 0, free_len = 0, lead_len = 0, gap_len = 0;

    iams_top DUT (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
        .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack),
        .irq_o(irq), .scl_i(scl), .scl_o(scl_od), .scl_oe_o(scl_oe), .sda_i(sda),
        .sda_o(sda_od), .sda_oe_o(sda_oe));
    iams_slave u_far (.clk_i(clk_i), .scl_oe_i(scl_oe), .sda_oe_i(sda_oe),
        .stretch_i(stretch), .scl_line_o(scl), .sda_line_o(sda));

    initial begin
        forever #25 clk_i = ~clk_i;
    end

    // ****************
    // Line timing monitor.
    // ****************
    // Records the length of each clock hold and release and the data release gap.
    always @(negedge clk_i) begin
        if (!rst_i) begin
            now++;
            if (scl_oe !== scl_q) begin
                if (scl_q) begin
                    hold_len = now - t_edge;
                    lead_len = now - t_sda;
                    sda_at_rel = sda_oe;
                end else begin
                    free_len = now - t_edge;
                end
                t_edge = now;
            end
            if (sda_oe && !sda_q) t_sda = now;
            if (!sda_oe && sda_q) gap_len = now - t_edge;
            scl_q = scl_oe;
            sda_q = sda_oe;
        end
    end

    // ****************
    // Tasks.
    // ****************
    task automatic results();
        if (n_errors == 0 && num_checks > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask : results

    task automatic wb_io(input logic w, input logic [7:0] a, input logic [7:0] d);
        int k;
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        sel <= 4'hf;
        wdat <= {24'h000000, d};
        // Ack and read data are taken at the rising edge that samples ack high.
        for (k = 0; k < 20; k++) begin
            @(posedge clk_i);
            if (ack === 1'b1) begin
                break;
            end
        end
        if (k == 20) begin
            `CHK("bus ack", 1'b1, ack)
            results();
        end
        rd = rdat[7:0];
        cyc <= 1'b0;
        stb <= 1'b0;
        @(posedge clk_i);
    endtask : wb_io

    task automatic rd_chk(input logic [7:0] a, input logic [7:0] e);
        wb_io(1'b0, a, 8'h00);
        `CHK("register", e, rd)
    endtask : rd_chk

    task automatic wait_idle();
        int k;
        for (k = 0; k < 60; k++) begin
            wb_io(1'b0, OFS_CTRL, 8'h00);
            if (rd[4:2] === 3'b000) break;
        end
        if (k == 60) begin
            `CHK("sequence end", 3'b000, rd[4:2])
            results();
        end
    endtask : wait_idle

    function automatic logic in_rng(input int v, input int lo, input int hi);
        return v >= lo && v <= hi;
    endfunction : in_rng

    // ****************
    // Main sequence.
    // ****************
    initial begin
        int s;
        repeat (3) @(posedge clk_i);
        rst_i <= 1'b0;
        @(posedge clk_i);
        for (int r = 0; r < 21; r++) begin
            wb_io(ROWS[r][16], ROWS[r][15:8], ROWS[r][7:0]);
            if (!ROWS[r][16]) `CHK("table read", ROWS[r][7:0], rd)
        end
        `CHK("irq idle", 1'b0, irq)
        for (int i = 0; i < 2; i++) begin
            s = i ? 0 : 6;
            stretch <= i ? 8'h00 : 8'h06;
            wb_io(1'b1, OFS_CTRL, i ? 8'h30 : 8'h10);
            wb_io(1'b1, OFS_BUF, 8'hc3);
            wait_idle();
            `CHK("ack level", ~i[0], sda_at_rel)
            `CHK("ack low time", 1'b1, in_rng(hold_len, T - 3, T + 3))
            `CHK("ack release", 1'b1, in_rng(free_len, T + s, T + s + 6))
            `CHK("clock held", 1'b1, scl_oe)
            rd_chk(OFS_BUSY, 8'h00);
            rd_chk(OFS_IRQ, 8'h02);
            `CHK("irq raised", 1'b1, irq)
            wb_io(1'b1, OFS_IRQ, 8'h02);
            stretch <= 8'h00;
            wb_io(1'b1, OFS_CTRL, 8'h04);
            wb_io(1'b1, OFS_BUF, 8'h3c);
            wait_idle();
            `CHK("stop lead", 1'b1, in_rng(lead_len, T, T + 6))
            `CHK("stop gap", 1'b1, in_rng(gap_len, T - 3, T + 3))
            rd_chk(OFS_STAT, 8'h10);
            rd_chk(OFS_IRQ, 8'h03);
            rd_chk(OFS_BUF, 8'h5a);
            wb_io(1'b1, OFS_MASK, 8'h00);
            `CHK("irq masked", 1'b0, irq)
            wb_io(1'b1, OFS_IRQ, 8'h03);
            wb_io(1'b1, OFS_MASK, 8'h03);
            rd_chk(OFS_IRQ, 8'h00);
            wb_io(1'b1, OFS_CTRL, 8'h01);
            rd_chk(OFS_STAT, 8'h00);
        end
        // Reset in the middle of a stop sequence returns the lines, irq, ack and the control, baud, mask and busy registers.
        wb_io(1'b1, OFS_CTRL, 8'h04);
        `CHK("stop data low", 1'b1, sda_oe)
        `CHK("stop clock low", 1'b1, scl_oe)
        rst_i <= 1'b1;
        repeat (2) @(posedge clk_i);
        rst_i <= 1'b0;
        @(posedge clk_i);
        `CHK("reset clock oe", 1'b0, scl_oe)
        `CHK("reset data oe", 1'b0, sda_oe)
        `CHK("reset irq", 1'b0, irq)
        `CHK("reset ack", 1'b0, ack)
        rd_chk(OFS_CTRL, 8'h00);
        rd_chk(OFS_BAUD, BAUD_RST);
        rd_chk(OFS_MASK, 8'h00);
        rd_chk(OFS_BUSY, 8'h00);
        results();
    end
endmodule : iams_top_test

// ### rtl/iams_brg.sv
// Baud rate generator: reloads on request and flags when it reaches zero.
`timescale 1ns/1ps
module iams_brg #(
    parameter int W = iams_pkg::BRG_W
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic load_i,
    input wire logic run_i,
    input wire logic [W-1:0] reload_i,
    output logic done_o
);
    import iams_pkg::*;

    typedef struct packed {
        logic [W-1:0] cnt;
    } iams_brg_t;

    iams_brg_t r;
    iams_brg_t next_r;

    always_comb begin
        next_r = r;
        if (load_i) begin
            next_r.cnt = reload_i;
        end else if (run_i && r.cnt != '0) begin
            next_r.cnt = r.cnt - 1'b1;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            r <= '0;
        end else begin
            r <= next_r;
        end
    end

    // The load cycle is masked so a stale zero never ends a new period.
    assign done_o = run_i && !load_i && r.cnt == '0;
endmodule : iams_brg

// ### rtl/iams_pkg.sv
// Constants and types shared by the acknowledge and stop sequencer.
package iams_pkg;
    // ****************************************
    // Bus geometry.
    // ****************************************
    localparam int WB_AW = 8;
    localparam int WB_DW = 32;
    localparam int BRG_W = 8;

    // ****************************************
    // Register byte offsets.
    // ****************************************
    localparam logic [7:0] OFS_CTRL = 8'h00;
    localparam logic [7:0] OFS_STAT = 8'h04;
    localparam logic [7:0] OFS_BAUD = 8'h08;
    localparam logic [7:0] OFS_BUF = 8'h0c;
    localparam logic [7:0] OFS_IRQ = 8'h10;
    localparam logic [7:0] OFS_MASK = 8'h14;
    localparam logic [7:0] OFS_BUSY = 8'h18;

    // ****************************************
    // Field positions.
    // ****************************************
    localparam int CTL_START = 0;
    localparam int CTL_RSTART = 1;
    localparam int CTL_STOP = 2;
    localparam int CTL_RECV = 3;
    localparam int CTL_ACK = 4;
    localparam int CTL_ACK_DATA_VALUE = 5;
    localparam int STAT_XMIT = 2;
    localparam int STAT_STOP = 4;
    localparam int IRQ_PORT = 0;
    localparam int IRQ_WRITE_COLLISION_FLAG = 1;
    localparam int BUSY_BIT = 0;
    localparam int BUSY_SEQ_LSB = 4;

    // ****************************************
    // Reset values.
    // ****************************************
    localparam logic [5:0] CTL_RST = 6'h00;
    localparam logic [7:0] BAUD_RST = 8'h09;
    localparam logic [7:0] BUF_RST = 8'h00;
    localparam logic [1:0] IRQ_RST = 2'h0;
    localparam logic [1:0] MASK_RST = 2'h0;

    // ****************************************
    // Types.
    // ****************************************
    typedef enum logic [3:0] {
        SEQ_IDLE = 4'h0,
        SEQ_ACK_LOW = 4'h1,
        SEQ_ACK_REL = 4'h2,
        SEQ_ACK_HIGH = 4'h3,
        SEQ_STP_SDA = 4'h4,
        SEQ_STP_WAIT = 4'h5,
        SEQ_STP_SCLH = 4'h6,
        SEQ_STP_DET = 4'h7,
        SEQ_STP_END = 4'h8
    } iams_seq_t;

    typedef struct packed {
        logic scl_oe;
        logic sda_oe;
    } iams_line_t;

    typedef struct packed {
        logic ack;
        logic [WB_DW-1:0] rdata;
    } iams_bus_t;
endpackage : iams_pkg

// ### rtl/iams_sync.sv
// Three-stage pin synchroniser that accepts a change once two stages agree.
`timescale 1ns/1ps
module iams_sync #(
    parameter logic RST_VAL = 1'b1
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic pin_i,
    output logic level_o
);
    import iams_pkg::*;

    typedef struct packed {
        logic s1;
        logic s2;
        logic s3;
        logic level;
    } iams_sync_t;

    iams_sync_t r;
    iams_sync_t next_r;

    always_comb begin
        next_r = r;
        next_r.s1 = pin_i;
        next_r.s2 = r.s1;
        next_r.s3 = r.s2;
        if (r.s2 == r.s3) begin
            next_r.level = r.s3;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            r <= {RST_VAL, RST_VAL, RST_VAL, RST_VAL};
        end else begin
            r <= next_r;
        end
    end

    assign level_o = r.level;
endmodule : iams_sync

// ### rtl/iams_top.sv
// Acknowledge and stop sequencer of a two-wire serial port master.
// What this block does
// RULE1 - Setting ack enable pulls SCL low and puts ack data on SDA.
// RULE2 - Software chooses ack data zero for ack, one for not-ack, beforehand.
// RULE3 - Ack: one generator period with SCL low, then SCL released.
// RULE4 - Wait for SCL high, count one more period, pull SCL low.
// RULE5 - Ack end clears ack enable, stops the generator, goes idle.
// RULE6 - Buffer write during ack sequence sets collision flag, buffer kept.
// RULE7 - After a receive or transmit, SCL stays held low.
// RULE8 - Setting stop enable first pulls SDA low.
// RULE9 - Once SDA reads low, reload the generator and count to zero.
// RULE10 - At timeout release SCL; release SDA one period later.
// RULE11 - SDA high while SCL high sets the stop-detected flag.
// RULE12 - One period after stop seen, clear stop enable, set port flag.
// RULE13 - Buffer write during stop sequence sets collision flag, write dropped.
// RULE14 - Busy reads high while any enable is set or a transmit runs.
`timescale 1ns/1ps
module iams_top (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [iams_pkg::WB_AW-1:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [iams_pkg::WB_DW-1:0] wb_dat_i,
    output logic [iams_pkg::WB_DW-1:0] wb_dat_o,
    output logic wb_ack_o,
    output logic irq_o,
    input wire logic scl_i,
    output logic scl_o,
    output logic scl_oe_o,
    input wire logic sda_i,
    output logic sda_o,
    output logic sda_oe_o
);
    import iams_pkg::*;

    // ****************************************
    // State.
    // ****************************************
    typedef struct packed {
        iams_seq_t seq;
        logic [5:0] ctl;
        logic [BRG_W-1:0] baud;
        logic [7:0] buffer;
        logic [1:0] flags;
        logic [1:0] mask;
        logic stop_seen;
        logic xmit;
        iams_line_t line;
        logic brg_load;
        logic brg_run;
        iams_bus_t bus;
        logic irq;
        // The lines are open drain, so the driven level is always low.
        logic scl_lvl;
        logic sda_lvl;
    } iams_state_t;

    // Every register outside the synchronisers and the baud generator lives in r; next_r is its next value.
    iams_state_t r;
    iams_state_t next_r;

    logic scl_s;
    logic sda_s;
    logic brg_done;
    logic req;
    logic wr;
    logic rd;
    logic busy;
    logic in_seq;
    logic [7:0] adr;
    logic [7:0] wdat;
    logic [7:0] rbyte;

    // ****************************************
    // Pin synchronisers and baud generator.
    // ****************************************
    // Both lines idle high, so the synchronisers reset to one.
    iams_sync #(
        .RST_VAL(1'b1)
    ) u_scl_sync (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .pin_i(scl_i),
        .level_o(scl_s)
    );

    iams_sync #(
        .RST_VAL(1'b1)
    ) u_sda_sync (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .pin_i(sda_i),
        .level_o(sda_s)
    );

    // The generator is reloaded from the baud register for every period.
    iams_brg #(
        .W(BRG_W)
    ) u_brg (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .load_i(r.brg_load),
        .run_i(r.brg_run),
        .reload_i(r.baud),
        .done_o(brg_done)
    );

    // ****************************************
    // Bus decode.
    // ****************************************
    // Gating with ack keeps each ack to one cycle; a request held on is acked again every other cycle.
    assign req = wb_cyc_i && wb_stb_i && !r.bus.ack;
    assign wr = req && wb_we_i && wb_sel_i[0];
    assign rd = req && !wb_we_i;
    assign adr = {wb_adr_i[7:2], 2'b00};
    assign wdat = wb_dat_i[7:0];
    // The ack and stop enable bits count as well, so a buffer write just after one is set collides.
    assign in_seq = r.seq != SEQ_IDLE || r.ctl[CTL_ACK] || r.ctl[CTL_STOP];
    assign busy = r.ctl[CTL_START] || r.ctl[CTL_RSTART] || r.ctl[CTL_STOP] ||
                  r.ctl[CTL_RECV] || r.ctl[CTL_ACK] || r.xmit; // RULE14

    // Read data is built here and registered in the ack cycle.
    always_comb begin
        rbyte = 8'h00;
        case (adr)
            OFS_CTRL: begin
                rbyte = {2'b00, r.ctl};
            end
            OFS_STAT: begin
                rbyte[STAT_STOP] = r.stop_seen;
                rbyte[STAT_XMIT] = r.xmit;
            end
            OFS_BAUD: begin
                rbyte = r.baud;
            end
            OFS_BUF: begin
                rbyte = r.buffer;
            end
            OFS_IRQ: begin
                rbyte = {6'h00, r.flags};
            end
            OFS_MASK: begin
                rbyte = {6'h00, r.mask};
            end
            OFS_BUSY: begin
                rbyte[BUSY_BIT] = busy;
                rbyte[BUSY_SEQ_LSB+:4] = r.seq;
            end
            default: begin
                rbyte = 8'h00;
            end
        endcase
    end

    // ****************************************
    // Next state.
    // ****************************************
    always_comb begin
        next_r = r;
        next_r.brg_load = 1'b0;
        next_r.scl_lvl = 1'b0;
        next_r.sda_lvl = 1'b0;
        next_r.bus.ack = req;
        next_r.bus.rdata = '0;
        // Read data stands for the ack cycle only and is zero otherwise.
        if (rd) begin
            next_r.bus.rdata = {24'h000000, rbyte};
        end

        // Software writes come first so hardware events below win.
        if (wr) begin
            case (adr)
                OFS_CTRL: begin
                    next_r.ctl = wdat[5:0];
                    if (wdat[CTL_START]) begin
                        next_r.stop_seen = 1'b0;
                    end
                end
                OFS_BAUD: begin
                    next_r.baud = wdat;
                end
                OFS_BUF: begin
                    if (in_seq) begin
                        next_r.flags[IRQ_WRITE_COLLISION_FLAG] = 1'b1; // RULE6 RULE13
                    end else begin
                        next_r.buffer = wdat;
                        next_r.xmit = 1'b1;
                    end
                end
                OFS_IRQ: begin
                    next_r.flags = r.flags & ~wdat[1:0];
                    if (in_seq && r.flags[IRQ_WRITE_COLLISION_FLAG]) begin
                        next_r.flags[IRQ_WRITE_COLLISION_FLAG] = next_r.flags[IRQ_WRITE_COLLISION_FLAG];
                    end
                end
                OFS_MASK: begin
                    next_r.mask = wdat[1:0];
                end
                default: begin
                    next_r.mask = next_r.mask;
                end
            endcase
        end

        // ****************************************
        // Line sequencer.
        // ****************************************
        // Ack: pull the clock, and the data line if ack data is zero, for one period, free the clock, wait to read it
        // high, count one more period, then pull the clock low and hold it.
        // Stop: pull the data line, wait to read it low, count a period, free
        // the clock, count a period, free the data line, wait for both lines
        // high, then count a last period before the flag is raised.
        // A slave stretching the clock or holding a line low only lengthens
        // the wait states; nothing times out inside the block.
        case (r.seq)
            SEQ_IDLE: begin
                if (r.ctl[CTL_ACK]) begin
                    next_r.seq = SEQ_ACK_LOW;
                    next_r.line.scl_oe = 1'b1; // RULE1
                    next_r.line.sda_oe = !r.ctl[CTL_ACK_DATA_VALUE]; // RULE1 RULE2
                    next_r.brg_load = 1'b1;
                    next_r.brg_run = 1'b1;
                    next_r.xmit = 1'b0;
                end else if (r.ctl[CTL_STOP]) begin
                    next_r.seq = SEQ_STP_SDA;
                    next_r.line.scl_oe = 1'b1; // RULE7
                    next_r.line.sda_oe = 1'b1; // RULE8
                    next_r.xmit = 1'b0;
                end
            end
            SEQ_ACK_LOW: begin
                if (brg_done) begin
                    next_r.line.scl_oe = 1'b0; // RULE3
                    next_r.brg_run = 1'b0;
                    next_r.seq = SEQ_ACK_REL;
                end
            end
            SEQ_ACK_REL: begin
                // A slave stretching the clock keeps the sequence here.
                if (scl_s) begin
                    next_r.brg_load = 1'b1; // RULE4
                    next_r.brg_run = 1'b1;
                    next_r.seq = SEQ_ACK_HIGH;
                end
            end
            SEQ_ACK_HIGH: begin
                if (brg_done) begin
                    // The clock is pulled low again and kept low for what follows.
                    next_r.line.scl_oe = 1'b1; // RULE4 RULE7
                    next_r.line.sda_oe = 1'b0;
                    next_r.ctl[CTL_ACK] = 1'b0; // RULE5
                    next_r.brg_run = 1'b0; // RULE5
                    next_r.seq = SEQ_IDLE; // RULE5
                end
            end
            SEQ_STP_SDA: begin
                if (!sda_s) begin
                    next_r.brg_load = 1'b1; // RULE9
                    next_r.brg_run = 1'b1;
                    next_r.seq = SEQ_STP_WAIT;
                end
            end
            SEQ_STP_WAIT: begin
                if (brg_done) begin
                    next_r.line.scl_oe = 1'b0; // RULE10
                    // The same generator then times the data release.
                    next_r.brg_load = 1'b1;
                    next_r.seq = SEQ_STP_SCLH;
                end
            end
            SEQ_STP_SCLH: begin
                if (brg_done) begin
                    next_r.line.sda_oe = 1'b0; // RULE10
                    next_r.brg_run = 1'b0;
                    next_r.seq = SEQ_STP_DET;
                end
            end
            SEQ_STP_DET: begin
                // Both lines must read high through the synchronisers.
                if (sda_s && scl_s) begin
                    next_r.stop_seen = 1'b1; // RULE11
                    next_r.brg_load = 1'b1;
                    next_r.brg_run = 1'b1;
                    next_r.seq = SEQ_STP_END;
                end
            end
            SEQ_STP_END: begin
                if (brg_done) begin
                    next_r.ctl[CTL_STOP] = 1'b0; // RULE12
                    next_r.flags[IRQ_PORT] = 1'b1; // RULE12
                    next_r.brg_run = 1'b0;
                    next_r.seq = SEQ_IDLE;
                end
            end
            default: begin
                next_r.seq = SEQ_IDLE;
                next_r.brg_run = 1'b0;
            end
        endcase

        next_r.irq = |(next_r.flags & next_r.mask);
    end

    // ****************************************
    // Registers.
    // ****************************************
    // Reset returns both lines to released and the port to idle.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            r.seq <= SEQ_IDLE;
            r.ctl <= CTL_RST;
            r.baud <= BAUD_RST;
            r.buffer <= BUF_RST;
            r.flags <= IRQ_RST;
            r.mask <= MASK_RST;
            r.stop_seen <= 1'b0;
            r.xmit <= 1'b0;
            r.line <= '0;
            r.brg_load <= 1'b0;
            r.brg_run <= 1'b0;
            r.bus <= '0;
            r.irq <= 1'b0;
            r.scl_lvl <= 1'b0;
            r.sda_lvl <= 1'b0;
        end else begin
            r <= next_r;
        end
    end

    // ****************************************
    // Outputs.
    // ****************************************
    assign wb_dat_o = r.bus.rdata;
    assign wb_ack_o = r.bus.ack;
    assign irq_o = r.irq;
    assign scl_oe_o = r.line.scl_oe;
    assign sda_oe_o = r.line.sda_oe;
    assign scl_o = r.scl_lvl;
    assign sda_o = r.sda_lvl;
endmodule : iams_top
